//--- sim/overtemp_fault_response_tb_top.sv
// testbench for the overtemperature fault response block
`default_nettype none
module overtemp_fault_response_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned CPM = 1;
   typedef struct {
      logic [7:0] wa;
      logic [7:0] wd;
      logic [7:0] ra;
      logic [7:0] exp;
   } row_type;
   logic mclk;
   logic rst = 1'b1;
   logic fault, reg_wr, reg_rd, pwr_enable, fault_latched;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   int err_total = 0;
   int n_checks = 0;
   int n;
   row_type rows [5] = '{'{8'h50, 8'h3f, 8'h50, 8'h3f},
      '{8'h50, 8'hc5, 8'h50, 8'hc5}, '{8'h4f, 8'h12, 8'h50, 8'hc5},
      '{8'h50, 8'ha8, 8'h51, 8'h00}, '{8'h50, 8'h00, 8'h50, 8'h00}};

   overtemp_fault_response #(.CYCLES_PER_MS(CPM)) uut (.i_mclk(mclk),
      .i_rst(rst), .i_fault(fault), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .o_pwr_enable(pwr_enable),
      .o_fault_latched(fault_latched));
   host_model host (.i_mclk(mclk), .i_reg_rdata(reg_rdata),
      .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
      .o_reg_wdata(reg_wdata), .o_fault(fault));

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %b got %b", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input int g);
      n_checks++;
      if (g < lo || g > hi) begin
         err_total++;
         $display("Error %s expected %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask

   // cycles until the enable reaches v, bounded by lim
   task automatic meas(input logic v, input int lim, output int c);
      c = 0;
      while (pwr_enable !== v && c < lim) begin
         @(posedge mclk);
         #1;
         c++;
      end
   endtask

   task automatic do_reset();
      @(posedge mclk);
      #1;
      rst = 1'b1;
      repeat (10) @(posedge mclk);
      #1;
      rst = 1'b0;
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      do_reset();
      host.rd(8'h50, q);
      chk("policy reset", 8'h00, q);
      chk_bit("enable reset", 1'b1, pwr_enable);
      foreach (rows[i]) begin
         host.wr(rows[i].wa, rows[i].wd);
         host.rd(rows[i].ra, q);
         chk("policy read", rows[i].exp, q);
      end
      // ignore: enable never drops
      host.set_fault(1'b1);
      meas(1'b0, 50, n);
      chk_rng("ignore enable", 50, 50, n);
      host.set_fault(1'b0);
      // hold off while fault lasts
      host.wr(8'h50, 8'hc0);
      host.set_fault(1'b1);
      meas(1'b0, 4, n);
      chk_rng("hold off", 1, 1, n);
      repeat (20) @(posedge mclk);
      #1;
      chk_bit("hold stays off", 1'b0, pwr_enable);
      host.set_fault(1'b0);
      meas(1'b1, 4, n);
      chk_rng("hold release", 1, 1, n);
      // ride through 20 cycles, then 558 cycle restart interval
      host.wr(8'h50, 8'h49);
      host.set_fault(1'b1);
      meas(1'b0, 40, n);
      chk_rng("ride delay", 20, 23, n);
      meas(1'b1, 700, n);
      chk_rng("ride interval", 556, 561, n);
      host.set_fault(1'b0);
      // shut down, one retry, then latched off
      host.wr(8'h50, 8'h88);
      host.set_fault(1'b1);
      meas(1'b0, 4, n);
      chk_rng("shutdown off", 1, 1, n);
      meas(1'b1, 300, n);
      chk_rng("retry interval", 251, 256, n);
      meas(1'b0, 4, n);
      chk_rng("retry fail", 1, 2, n);
      repeat (2) @(posedge mclk);
      #1;
      chk_bit("latched", 1'b1, fault_latched);
      repeat (300) @(posedge mclk);
      #1;
      chk_bit("latched stays off", 1'b0, pwr_enable);
      host.set_fault(1'b0);
      host.wr(8'h50, 8'h00);
      repeat (5) @(posedge mclk);
      #1;
      chk_bit("latch after write", 1'b1, fault_latched);
      chk_bit("enable after write", 1'b0, pwr_enable);
      do_reset();
      chk_bit("latch after reset", 1'b0, fault_latched);
      chk_bit("enable after reset", 1'b1, pwr_enable);
      // unlimited retries never latch
      host.wr(8'h50, 8'hb8);
      host.set_fault(1'b1);
      repeat (3) begin
         meas(1'b0, 4, n);
         chk_rng("endless off", 1, 2, n);
         meas(1'b1, 300, n);
         chk_rng("endless interval", 251, 256, n);
      end
      chk_bit("endless latch", 1'b0, fault_latched);
      host.set_fault(1'b0);
      finish_test();
   end

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      finish_test();
   end
endmodule
`default_nettype wire

//--- sim/overtemp_host_model.sv
// host side model: register bus master and fault source
`default_nettype none
module host_model (
   input wire logic i_mclk,
   input wire logic [7:0] i_reg_rdata,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_fault
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle bus at time zero
   initial begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
      o_fault = 1'b0;
   end

   // one write cycle, bus inverted once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #1;
      o_reg_wr = 1'b1;
      o_reg_addr = a;
      o_reg_wdata = d;
      @(posedge i_mclk);
      #1;
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask

   // one read cycle, data taken after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge i_mclk);
      #1;
      o_reg_rd = 1'b1;
      o_reg_addr = a;
      @(posedge i_mclk);
      #1;
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      q = i_reg_rdata;
   endtask

   // fault level change just after an edge
   task automatic set_fault(input logic v);
      @(posedge i_mclk);
      #1;
      o_fault = v;
   endtask
endmodule
`default_nettype wire

//--- src/delay_timer.sv
// down counter that pulses when a loaded delay has run out
`default_nettype none
module delay_timer #(
   parameter int WIDTH = 32
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic i_clear,
   input wire logic [WIDTH-1:0] i_count,
   output logic o_done
);
   logic [WIDTH-1:0] cnt;

   // count down from the loaded value
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt <= '0;
      end else if (i_load) begin
         cnt <= i_count;
      end else if (i_clear) begin
         cnt <= '0;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   // one-cycle pulse as the count reaches zero
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= (cnt == {{(WIDTH-1){1'b0}}, 1'b1}) && !i_load && !i_clear;
      end
   end
endmodule
`default_nettype wire

//--- src/overtemp_consts.svh
// constants for the overtemperature fault response block
`ifndef OVERTEMP_CONSTS_SVH
`define OVERTEMP_CONSTS_SVH

`define OTP_ADDR 8'h50
`define OTP_RESET 8'h00
`define OTP_ACT_HI 7
`define OTP_ACT_LO 6
`define OTP_RETRY_HI 5
`define OTP_RETRY_LO 3
`define OTP_DLY_HI 2
`define OTP_DLY_LO 0
`define OTP_RETRY_INF 3'h7
`define OTP_CLK_MHZ 32'h000000c8
`define OTP_CYC_PER_MS (`OTP_CLK_MHZ * 32'h000003e8)
// shutdown delays in ms
`define OTP_D1_MS_0 32'h0000000a
`define OTP_D1_MS_1 32'h00000014
`define OTP_D1_MS_2 32'h00000028
`define OTP_D1_MS_3 32'h00000050
`define OTP_D1_MS_4 32'h000000a0
`define OTP_D1_MS_5 32'h00000140
`define OTP_D1_MS_6 32'h00000280
`define OTP_D1_MS_7 32'h00000500
// restart intervals in ms
`define OTP_D2_MS_0 32'h000000fc
`define OTP_D2_MS_1 32'h0000022e
`define OTP_D2_MS_2 32'h0000039c
`define OTP_D2_MS_3 32'h000004ec
`define OTP_D2_MS_4 32'h0000063c
`define OTP_D2_MS_5 32'h0000078c
`define OTP_D2_MS_6 32'h000008dc
`define OTP_D2_MS_7 32'h00000a2c

`endif

//--- src/overtemp_fault_response.sv
// overtemperature fault response policy and power stage enable
`include "overtemp_consts.svh"
`default_nettype none
module overtemp_fault_response #(
   parameter int unsigned CYCLES_PER_MS = `OTP_CYC_PER_MS
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_fault,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_pwr_enable,
   output logic o_fault_latched
);
   overtemp_pkg::state_type state;
   overtemp_pkg::state_type next_state;
   overtemp_pkg::action_type action;
   logic [7:0] policy;
   logic [2:0] retry_field;
   logic [2:0] delay_code;
   logic [2:0] retries_left;
   logic wr_hit;
   logic rd_hit;
   logic decide;
   logic restart;
   logic t_load;
   logic t_clear;
   logic t_done;
   logic [31:0] t_count;

   // delay table lookup in ms, sel 0 = shutdown delay, 1 = interval
   function automatic logic [31:0] delay_ms(input logic sel,
                                            input logic [2:0] code);
      logic [31:0] ms;
      ms = 32'h00000000;
      case ({sel, code})
         4'h0: ms = `OTP_D1_MS_0;
         4'h1: ms = `OTP_D1_MS_1;
         4'h2: ms = `OTP_D1_MS_2;
         4'h3: ms = `OTP_D1_MS_3;
         4'h4: ms = `OTP_D1_MS_4;
         4'h5: ms = `OTP_D1_MS_5;
         4'h6: ms = `OTP_D1_MS_6;
         4'h7: ms = `OTP_D1_MS_7;
         4'h8: ms = `OTP_D2_MS_0;
         4'h9: ms = `OTP_D2_MS_1;
         4'ha: ms = `OTP_D2_MS_2;
         4'hb: ms = `OTP_D2_MS_3;
         4'hc: ms = `OTP_D2_MS_4;
         4'hd: ms = `OTP_D2_MS_5;
         4'he: ms = `OTP_D2_MS_6;
         default: ms = `OTP_D2_MS_7;
      endcase
      return ms;
   endfunction

   // field split and register decode
   assign action = overtemp_pkg::action_type'(
      policy[`OTP_ACT_HI:`OTP_ACT_LO]);
   assign retry_field = policy[`OTP_RETRY_HI:`OTP_RETRY_LO];
   assign delay_code = policy[`OTP_DLY_HI:`OTP_DLY_LO];
   assign wr_hit = i_reg_wr && (i_reg_addr == `OTP_ADDR);
   assign rd_hit = i_reg_rd && (i_reg_addr == `OTP_ADDR);

   // policy register write
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         policy <= `OTP_RESET;
      end else if (wr_hit) begin
         policy <= i_reg_wdata;
      end
   end

   // read data, zero for any other address
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rd_hit ? policy : 8'h00;
      end
   end

   assign decide = !wr_hit && i_fault &&
      (((state == overtemp_pkg::ST_RUN) &&
        (action == overtemp_pkg::ACT_SHUTDOWN)) ||
       ((state == overtemp_pkg::ST_RIDE) && t_done));
   assign restart = !wr_hit && (state == overtemp_pkg::ST_OFF_WAIT) &&
      t_done;

   // next state of the response sequencer
   always_comb begin
      next_state = state;
      case (state)
         overtemp_pkg::ST_RUN: begin
            if (decide) begin
               if (retry_field == `OTP_RETRY_INF || retries_left != 3'h0) begin
                  next_state = overtemp_pkg::ST_OFF_WAIT;
               end else begin
                  next_state = overtemp_pkg::ST_LATCHED;
               end
            end else if (i_fault && !wr_hit) begin
               case (action)
                  overtemp_pkg::ACT_RIDE: next_state = overtemp_pkg::ST_RIDE;
                  overtemp_pkg::ACT_HOLD: next_state = overtemp_pkg::ST_HOLD;
                  default: next_state = overtemp_pkg::ST_RUN;
               endcase
            end
         end
         overtemp_pkg::ST_RIDE: begin
            if (wr_hit || !i_fault) begin
               next_state = overtemp_pkg::ST_RUN;
            end else if (decide) begin
               if (retry_field == `OTP_RETRY_INF || retries_left != 3'h0) begin
                  next_state = overtemp_pkg::ST_OFF_WAIT;
               end else begin
                  next_state = overtemp_pkg::ST_LATCHED;
               end
            end
         end
         overtemp_pkg::ST_OFF_WAIT: begin
            if (wr_hit || restart) begin
               next_state = overtemp_pkg::ST_RUN;
            end
         end
         overtemp_pkg::ST_HOLD: begin
            if (!i_fault) begin
               next_state = overtemp_pkg::ST_RUN;
            end
         end
         overtemp_pkg::ST_LATCHED: begin
            next_state = overtemp_pkg::ST_LATCHED;
         end
         default: next_state = overtemp_pkg::ST_RUN;
      endcase
   end

   // state, enable and latched flags
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= overtemp_pkg::ST_RUN;
         o_pwr_enable <= 1'b1;
         o_fault_latched <= 1'b0;
      end else begin
         state <= next_state;
         o_pwr_enable <= (next_state == overtemp_pkg::ST_RUN) ||
            (next_state == overtemp_pkg::ST_RIDE);
         o_fault_latched <= (next_state == overtemp_pkg::ST_LATCHED);
      end
   end

   // reload attempts on write or cool
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         retries_left <= 3'(`OTP_RESET >> `OTP_RETRY_LO);
      end else if (wr_hit) begin
         retries_left <= i_reg_wdata[`OTP_RETRY_HI:`OTP_RETRY_LO];
      end else if (!i_fault) begin
         retries_left <= retry_field;
      end else if (restart && retry_field != `OTP_RETRY_INF &&
                   retries_left != 3'h0) begin
         retries_left <= retries_left - 3'h1;
      end
   end

   // shutdown delay or interval loaded on entry
   assign t_load = (next_state != state) &&
      ((next_state == overtemp_pkg::ST_RIDE) ||
       (next_state == overtemp_pkg::ST_OFF_WAIT));
   assign t_clear = (next_state != overtemp_pkg::ST_RIDE) &&
      (next_state != overtemp_pkg::ST_OFF_WAIT);
   assign t_count = 32'(delay_ms(next_state == overtemp_pkg::ST_OFF_WAIT,
                                 delay_code) * CYCLES_PER_MS);

   delay_timer #(
      .WIDTH(32)
   ) u_timer (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_load(t_load),
      .i_clear(t_clear),
      .i_count(t_count),
      .o_done(t_done)
   );

   // checks
   sequence s_hot_hold;
      state == overtemp_pkg::ST_RUN && i_fault && !wr_hit &&
         action == overtemp_pkg::ACT_HOLD;
   endsequence
   sequence s_held_off;
      state == overtemp_pkg::ST_HOLD && !o_pwr_enable;
   endsequence

   property p_ignore;
      @(posedge i_mclk) disable iff (i_rst)
      (state == overtemp_pkg::ST_RUN && !wr_hit &&
       action == overtemp_pkg::ACT_IGNORE) |=> state == overtemp_pkg::ST_RUN
         && o_pwr_enable;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("ignore code left run state");

   property p_ride_start;
      @(posedge i_mclk) disable iff (i_rst)
      (state == overtemp_pkg::ST_RUN && i_fault && !wr_hit &&
       action == overtemp_pkg::ACT_RIDE) |=> state == overtemp_pkg::ST_RIDE
         && o_pwr_enable;
   endproperty
   a_ride_start: assert property (p_ride_start)
      else $error("ride through did not start with output on");

   property p_shutdown;
      @(posedge i_mclk) disable iff (i_rst)
      (state == overtemp_pkg::ST_RUN && i_fault && !wr_hit &&
       action == overtemp_pkg::ACT_SHUTDOWN) |=> !o_pwr_enable;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("shutdown code left output on");

   property p_hold;
      @(posedge i_mclk) disable iff (i_rst)
      s_hot_hold |=> s_held_off;
   endproperty
   a_hold: assert property (p_hold)
      else $error("hold code did not turn output off");

   property p_hold_release;
      @(posedge i_mclk) disable iff (i_rst)
      (s_held_off ##0 !i_fault) |=> o_pwr_enable;
   endproperty
   a_hold_release: assert property (p_hold_release)
      else $error("output not re-enabled after fault cleared");

   property p_retry_inf;
      @(posedge i_mclk) disable iff (i_rst)
      (decide && retry_field == `OTP_RETRY_INF) |=>
         state == overtemp_pkg::ST_OFF_WAIT;
   endproperty
   a_retry_inf: assert property (p_retry_inf)
      else $error("unlimited retry setting latched off");

   property p_spent;
      @(posedge i_mclk) disable iff (i_rst)
      (decide && retry_field != `OTP_RETRY_INF && retries_left == 3'h0)
         |=> o_fault_latched && !o_pwr_enable;
   endproperty
   a_spent: assert property (p_spent)
      else $error("spent retries did not latch off");

   property p_latched;
      @(posedge i_mclk) disable iff (i_rst)
      o_fault_latched |=> o_fault_latched && !o_pwr_enable;
   endproperty
   a_latched: assert property (p_latched)
      else $error("latched fault left without reset");

   property p_interval;
      @(posedge i_mclk) disable iff (i_rst)
      (state == overtemp_pkg::ST_OFF_WAIT && !t_done && !wr_hit)
         |=> !o_pwr_enable;
   endproperty
   a_interval: assert property (p_interval)
      else $error("restart before interval ran out");

   property p_delay;
      @(posedge i_mclk) disable iff (i_rst)
      (state == overtemp_pkg::ST_RIDE && !t_done && i_fault && !wr_hit)
         |=> o_pwr_enable;
   endproperty
   a_delay: assert property (p_delay)
      else $error("output off before shutdown delay ran out");

   property p_reload;
      @(posedge i_mclk) disable iff (i_rst)
      wr_hit |=> retries_left == $past(i_reg_wdata[`OTP_RETRY_HI:`OTP_RETRY_LO])
         && state != overtemp_pkg::ST_RIDE;
   endproperty
   a_reload: assert property (p_reload)
      else $error("policy write did not reload sequencing");
endmodule
`default_nettype wire

//--- src/overtemp_pkg.sv
// types for the overtemperature fault response block
`default_nettype none
package overtemp_pkg;
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_RIDE = 5'h02,
      ST_OFF_WAIT = 5'h04,
      ST_HOLD = 5'h08,
      ST_LATCHED = 5'h10
   } state_type;
   typedef enum logic [1:0] {
      ACT_IGNORE = 2'h0,
      ACT_RIDE = 2'h1,
      ACT_SHUTDOWN = 2'h2,
      ACT_HOLD = 2'h3
   } action_type;
endpackage
`default_nettype wire
